// *** hw/tmsp_regs.svh ***
// Constants of the transceiver management serial port: offsets, fields, resets, timing.
// Assumes a 10 MHz ref_clk and a host that masters the 2-wire management bus.
`ifndef TMSP_REGS_SVH
`define TMSP_REGS_SVH

`define TMSP_ADDR_ID       7'h50
`define TMSP_ADDR_DIAG     7'h51

`define TMSP_REG_CTRL      8'h00
`define TMSP_REG_STATUS    8'h04
`define TMSP_REG_IRQ_STAT  8'h08
`define TMSP_REG_IRQ_MASK  8'h0C
`define TMSP_REG_ID_PROG   8'h10

`define TMSP_CTRL_SOFT_TXDIS 0
`define TMSP_CTRL_EXT_CAL    1
`define TMSP_CTRL_RESET      2'h0
`define TMSP_MASK_RESET      5'h00

`define TMSP_IRQ_ALARM     0
`define TMSP_IRQ_WARN      1
`define TMSP_IRQ_LOS       2
`define TMSP_IRQ_FAULT     3
`define TMSP_IRQ_HOSTWR    4

`define TMSP_DIAG_CALTYPE  8'h5C
`define TMSP_DIAG_MON_BASE 8'h60
`define TMSP_DIAG_MON_LAST 8'h69
`define TMSP_DIAG_ALARM    8'h70
`define TMSP_DIAG_WARN     8'h74
`define TMSP_CAL_INT       8'h60
`define TMSP_CAL_EXT       8'h50

`define TMSP_CLK_NS        100
`define TMSP_TXDIS_MAX_US  10
`define TMSP_TXDIS_CYCLES  ((`TMSP_TXDIS_MAX_US * 1000) / `TMSP_CLK_NS)

`endif

// *** hw/tmsp_pkg.sv ***
// Types of the transceiver management serial port.
// Assumes the constants header is included by the design file that uses it.
package tmsp_pkg;

  typedef enum logic [8:0] {
    st_idle  = 9'h001,
    st_dev   = 9'h002,
    st_acka  = 9'h004,
    st_ptr   = 9'h008,
    st_ackp  = 9'h010,
    st_wdata = 9'h020,
    st_ackw  = 9'h040,
    st_rdata = 9'h080,
    st_rack  = 9'h100
  } tmsp_state_t;

  // Monitor readings, temperature in the top field
  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] vcc;
    logic [15:0] bias;
    logic [15:0] txp;
    logic [15:0] rxp;
  } tmsp_mon_t;

  typedef struct packed {
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_p;
    logic        sda_s1;
    logic        sda_s2;
    logic        sda_p;
    logic        txd_s1;
    logic        txd_s2;
    logic        los_s1;
    logic        los_s2;
    logic        los_p;
    logic        flt_s1;
    logic        flt_s2;
    logic        flt_p;
    logic        tx_en;
    tmsp_state_t fsm;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic        diag;
    logic        rw;
    logic        host_ack;
    logic [7:0]  ptr;
    logic        sda_oe;
    logic [1:0]  ctrl;
    logic [4:0]  irq_stat;
    logic [4:0]  irq_mask;
    logic        alarm_p;
    logic        warn_p;
    logic [31:0] rdata;
  } tmsp_regs_t;

endpackage

// *** hw/tmsp_mgmt_port.sv ***
// Management side of a pluggable transceiver: 2-wire slave with an identification
// map and a diagnostic map, loss-of-signal, fault and transmit shutoff handling.
// Assumes the host masters the 2-wire bus slowly against ref_clk (8+ samples per bit)
// and that mon_raw comes from converter logic on ref_clk.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ns
`include "tmsp_regs.svh"

module tmsp_mgmt_port
  import tmsp_pkg::*;
#(
  parameter logic [79:0] HI_ALARM   = {5{16'hFFFF}},
  parameter logic [79:0] LO_ALARM   = {5{16'h0000}},
  parameter logic [79:0] HI_WARN    = {5{16'hFFFF}},
  parameter logic [79:0] LO_WARN    = {5{16'h0000}},
  parameter logic [79:0] CAL_OFFSET = {5{16'h0000}}
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        mgmt_clock_pin,
  input  wire logic        mgmt_data_i,
  output wire logic        mgmt_data_o,
  output wire logic        mgmt_data_oe,
  output wire logic        presence_strap_o,
  output wire logic        presence_strap_oe,
  input  wire logic        tx_disable_pin,
  output wire logic        tx_enable,
  input  wire logic        laser_fault_det,
  output wire logic        tx_fault,
  input  wire logic        rx_signal_detect,
  output wire logic        rx_signal_lost,
  input  wire tmsp_mon_t   mon_raw,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output wire logic [31:0] reg_rdata,
  output wire logic        irq
);

  localparam int TXDIS_CYC = `TMSP_TXDIS_CYCLES;

  tmsp_regs_t q;
  tmsp_regs_t n;
  logic [7:0] id_mem   [256];
  logic [7:0] diag_mem [128];
  logic [79:0] rep;
  logic [9:0]  alarm;
  logic [9:0]  warn;
  logic [7:0]  rd_byte;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic        host_wr;
  logic        ptr_inc;

  // Calibration and range flags per monitor; unsigned compare, hi in the odd bit
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_mon
      localparam int B = 16 * (4 - gi);
      assign rep[B +: 16] = mon_raw[B +: 16]
                          + (q.ctrl[`TMSP_CTRL_EXT_CAL] ? 16'h0000 : CAL_OFFSET[B +: 16]);
      assign alarm[2*(4-gi)+1] = rep[B +: 16] > HI_ALARM[B +: 16];
      assign alarm[2*(4-gi)]   = rep[B +: 16] < LO_ALARM[B +: 16];
      assign warn[2*(4-gi)+1]  = rep[B +: 16] > HI_WARN[B +: 16];
      assign warn[2*(4-gi)]    = rep[B +: 16] < LO_WARN[B +: 16];
    end
  endgenerate

  // Byte presented to the host at the current pointer
  always_comb begin
    logic [2:0] idx;
    idx = 3'((q.ptr - `TMSP_DIAG_MON_BASE) >> 1);
    rd_byte = 8'h00;
    if (!q.diag) begin
      rd_byte = id_mem[q.ptr];
    end else if (q.ptr[7]) begin
      rd_byte = diag_mem[q.ptr[6:0]];
    end else if (q.ptr == `TMSP_DIAG_CALTYPE) begin
      rd_byte = q.ctrl[`TMSP_CTRL_EXT_CAL] ? `TMSP_CAL_EXT : `TMSP_CAL_INT;
    end else if (q.ptr >= `TMSP_DIAG_MON_BASE && q.ptr <= `TMSP_DIAG_MON_LAST) begin
      rd_byte = q.ptr[0] ? rep[16*(4-idx) +: 8] : rep[16*(4-idx)+8 +: 8];
    end else if (q.ptr == `TMSP_DIAG_ALARM) begin
      rd_byte = alarm[9:2];
    end else if (q.ptr == `TMSP_DIAG_ALARM + 8'h01) begin
      rd_byte = {alarm[1:0], 6'h00};
    end else if (q.ptr == `TMSP_DIAG_WARN) begin
      rd_byte = warn[9:2];
    end else if (q.ptr == `TMSP_DIAG_WARN + 8'h01) begin
      rd_byte = {warn[1:0], 6'h00};
    end
  end

  // Bus conditions seen on the synchronised lines only
  assign scl_rise = q.scl_s2 & ~q.scl_p;
  assign scl_fall = ~q.scl_s2 & q.scl_p;
  assign start_c  = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
  assign stop_c   = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;
  // Only the user half of the diagnostic map accepts host data
  assign host_wr  = (q.fsm == st_wdata) & scl_fall & (q.cnt == 4'h8)
                  & q.diag & q.ptr[7];
  assign ptr_inc  = (n.ptr != q.ptr) & ~(scl_fall & q.fsm == st_ptr);

  // Next state of everything
  always_comb begin
    n = q;
    n.scl_s1 = mgmt_clock_pin;
    n.scl_s2 = q.scl_s1;
    n.scl_p  = q.scl_s2;
    n.sda_s1 = mgmt_data_i;
    n.sda_s2 = q.sda_s1;
    n.sda_p  = q.sda_s2;
    n.txd_s1 = tx_disable_pin;
    n.txd_s2 = q.txd_s1;
    n.los_s1 = ~rx_signal_detect;
    n.los_s2 = q.los_s1;
    n.los_p  = q.los_s2;
    n.flt_s1 = laser_fault_det;
    n.flt_s2 = q.flt_s1;
    n.flt_p  = q.flt_s2;
    n.tx_en  = ~(q.txd_s2 | q.ctrl[`TMSP_CTRL_SOFT_TXDIS]);
    n.alarm_p = |alarm;
    n.warn_p  = |warn;

    if (start_c) begin
      // Repeated start keeps the pointer for a random read
      n.fsm    = st_dev;
      n.cnt    = 4'h0;
      n.sda_oe = 1'b0;
    end else if (stop_c) begin
      n.fsm    = st_idle;
      n.sda_oe = 1'b0;
    end else begin
      case (q.fsm)
        st_dev, st_ptr, st_wdata: begin
          if (scl_rise && q.cnt < 4'h8) begin
            n.sh  = {q.sh[6:0], q.sda_s2};
            n.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == 4'h8) begin
            n.cnt    = 4'h0;
            n.sda_oe = 1'b1;
            if (q.fsm == st_dev) begin
              if (q.sh[7:1] == `TMSP_ADDR_ID || q.sh[7:1] == `TMSP_ADDR_DIAG) begin
                n.diag = q.sh[1];
                n.rw   = q.sh[0];
                n.fsm  = st_acka;
              end else begin
                n.sda_oe = 1'b0;
                n.fsm    = st_idle;
              end
            end else if (q.fsm == st_ptr) begin
              n.ptr = q.sh;
              n.fsm = st_ackp;
            end else begin
              n.ptr = q.ptr + 8'h01;
              n.fsm = st_ackw;
            end
          end
        end
        st_acka, st_ackp, st_ackw: begin
          if (scl_fall) begin
            if (q.fsm == st_acka && q.rw) begin
              n.sh     = rd_byte;
              n.ptr    = q.ptr + 8'h01;
              n.sda_oe = ~rd_byte[7];
              n.cnt    = 4'h1;
              n.fsm    = st_rdata;
            end else begin
              n.sda_oe = 1'b0;
              n.fsm    = (q.fsm == st_acka) ? st_ptr : st_wdata;
            end
          end
        end
        st_rdata: begin
          if (scl_fall) begin
            if (q.cnt == 4'h8) begin
              n.sda_oe = 1'b0;
              n.fsm    = st_rack;
            end else begin
              n.sda_oe = ~q.sh[6];
              n.sh     = {q.sh[6:0], 1'b0};
              n.cnt    = q.cnt + 4'h1;
            end
          end
        end
        st_rack: begin
          if (scl_rise) begin
            n.host_ack = ~q.sda_s2;
          end else if (scl_fall) begin
            if (q.host_ack) begin
              n.sh     = rd_byte;
              n.ptr    = q.ptr + 8'h01;
              n.sda_oe = ~rd_byte[7];
              n.cnt    = 4'h1;
              n.fsm    = st_rdata;
            end else begin
              n.fsm = st_idle;
            end
          end
        end
        st_idle: begin
          n.sda_oe = 1'b0;
        end
        default: begin
          n.fsm    = st_idle;
          n.sda_oe = 1'b0;
        end
      endcase
    end

    // Register port; the read answer stands one cycle only
    n.rdata = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        `TMSP_REG_CTRL:     n.ctrl     = reg_wdata[1:0];
        `TMSP_REG_IRQ_MASK: n.irq_mask = reg_wdata[4:0];
        default:            n.ctrl     = q.ctrl;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `TMSP_REG_CTRL:     n.rdata = {30'h0, q.ctrl};
        `TMSP_REG_STATUS:   n.rdata = {18'h0, q.ptr, (q.fsm != st_idle), |warn, |alarm,
                                       q.flt_s2, q.los_s2, q.tx_en};
        `TMSP_REG_IRQ_STAT: n.rdata = {27'h0, q.irq_stat};
        `TMSP_REG_IRQ_MASK: n.rdata = {27'h0, q.irq_mask};
        default:            n.rdata = 32'h0000_0000;
      endcase
    end

    // Sticky events; a new event beats a write-one clear in the same cycle
    n.irq_stat = q.irq_stat & ~((reg_wr && reg_addr == `TMSP_REG_IRQ_STAT) ?
                                reg_wdata[4:0] : 5'h00);
    n.irq_stat[`TMSP_IRQ_ALARM]  = n.irq_stat[`TMSP_IRQ_ALARM]  | (|alarm & ~q.alarm_p);
    n.irq_stat[`TMSP_IRQ_WARN]   = n.irq_stat[`TMSP_IRQ_WARN]   | (|warn & ~q.warn_p);
    n.irq_stat[`TMSP_IRQ_LOS]    = n.irq_stat[`TMSP_IRQ_LOS]    | (q.los_s2 & ~q.los_p);
    n.irq_stat[`TMSP_IRQ_FAULT]  = n.irq_stat[`TMSP_IRQ_FAULT]  | (q.flt_s2 & ~q.flt_p);
    n.irq_stat[`TMSP_IRQ_HOSTWR] = n.irq_stat[`TMSP_IRQ_HOSTWR] | host_wr;
  end

  // State register; idle bus lines and a disabled transmitter after reset
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      q <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_p: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
             sda_p: 1'b1, txd_s1: 1'b1, txd_s2: 1'b1, fsm: st_idle,
             ctrl: `TMSP_CTRL_RESET, irq_mask: `TMSP_MASK_RESET, default: '0};
    end else begin
      q <= n;
    end
  end

  // Map storage has no reset; factory loads the identification map over the port
  always_ff @(posedge ref_clk) begin
    if (reg_wr && reg_addr == `TMSP_REG_ID_PROG) begin
      id_mem[reg_wdata[15:8]] <= reg_wdata[7:0];
    end
    if (host_wr) begin
      diag_mem[q.ptr[6:0]] <= q.sh;
    end
  end

  // Open-drain data pin drives only low; strap pulled to ground permanently
  assign mgmt_data_o       = 1'b0;
  assign mgmt_data_oe      = q.sda_oe;
  assign presence_strap_o  = 1'b0;
  assign presence_strap_oe = 1'b1;
  assign tx_enable         = q.tx_en;
  assign tx_fault          = q.flt_s2;
  assign rx_signal_lost    = q.los_s2;
  assign reg_rdata         = q.rdata;
  assign irq               = |(q.irq_stat & q.irq_mask);

  // Checks on the block's own behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  AST_TXDIS: assert property (tx_disable_pin |-> ##[1:TXDIS_CYC] !tx_enable)
    else $error("transmitter not off after shutoff input");
  AST_TXDIS_HOLD: assert property (tx_disable_pin [*4] |-> !tx_enable)
    else $error("transmitter on while shutoff input high");
  AST_LOS: assert property (!rx_signal_detect [*3] |-> rx_signal_lost)
    else $error("signal loss not reported");
  AST_FAULT: assert property (laser_fault_det [*3] |-> tx_fault)
    else $error("laser fault not reported");
  AST_STRAP: assert property (presence_strap_oe && !presence_strap_o)
    else $error("presence strap not grounded");
  AST_SDA_EDGE: assert property ($changed(mgmt_data_oe) |-> !q.scl_s2)
    else $error("data line changed while clock high");
  AST_START: assert property (start_c |=> q.fsm == st_dev && q.cnt == 4'h0)
    else $error("start condition not taken");
  AST_ADDR: assert property ($rose(q.fsm == st_acka) |-> $past(q.sh[7:2]) == 6'h28
                             && q.diag == $past(q.sh[1]))
    else $error("acknowledged a foreign device address");
  AST_WRPROT: assert property (host_wr |-> q.diag && q.ptr >= 8'h80)
    else $error("write into a protected byte");
  AST_WRAP: assert property (ptr_inc && q.ptr == 8'hFF |=> q.ptr == 8'h00)
    else $error("pointer did not wrap");
  AST_ACK: assert property (q.fsm == st_ackp && !stop_c && !start_c |-> q.sda_oe)
    else $error("pointer byte not acknowledged");

  // Line and framing: open drain only pulls low, idle bus is left alone
  AST_OD_LOW: assert property (!mgmt_data_o)
    else $error("data pin driven high");
  AST_IDLE_REL: assert property (q.fsm == st_idle |-> !q.sda_oe)
    else $error("data line held while bus idle");
  AST_NACK_FOREIGN: assert property (scl_fall && q.fsm == st_dev
                                     && q.cnt == 4'h8 && q.sh[7:2] != 6'h28 |=> !q.sda_oe)
    else $error("foreign device address acknowledged");
  AST_RDBIT: assert property (q.fsm == st_rdata |-> q.sda_oe == ~q.sh[7])
    else $error("read bit does not match byte");

  // Status pins follow their synchronised inputs both ways; soft disable turns the transmitter off; external calibration reads raw
  AST_LOS_CLR: assert property (rx_signal_detect [*3] |-> !rx_signal_lost)
    else $error("signal loss reported with signal present");
  AST_FAULT_CLR: assert property (!laser_fault_det [*3] |-> !tx_fault)
    else $error("laser fault reported without fault");
  AST_TX_ON: assert property (!tx_disable_pin [*4] ##0 $stable(q.ctrl)
                              && !q.ctrl[`TMSP_CTRL_SOFT_TXDIS] |-> tx_enable)
    else $error("transmitter off with shutoff input low");
  AST_TXDIS_SOFT: assert property (q.ctrl[`TMSP_CTRL_SOFT_TXDIS] |=> !tx_enable)
    else $error("transmitter on under soft disable");
  AST_CAL_EXT: assert property (q.ctrl[`TMSP_CTRL_EXT_CAL] |-> rep == mon_raw)
    else $error("external mode value not raw");

  // Events land in the sticky status and stay until cleared
  AST_HOSTWR_IRQ: assert property (host_wr |=> q.irq_stat[`TMSP_IRQ_HOSTWR])
    else $error("host write event lost");
  AST_STICKY: assert property (q.irq_stat[`TMSP_IRQ_HOSTWR]
                               && !(reg_wr && reg_addr == `TMSP_REG_IRQ_STAT)
                               |=> q.irq_stat[`TMSP_IRQ_HOSTWR])
    else $error("sticky event dropped without clear");
  AST_ALARM_SET: assert property (|alarm && !q.alarm_p |=> q.irq_stat[`TMSP_IRQ_ALARM])
    else $error("alarm event lost");
  AST_LOS_SET: assert property ($rose(q.los_s2) |=> q.irq_stat[`TMSP_IRQ_LOS])
    else $error("signal loss event lost");

  // Main scenarios seen at least once
  COV_READ: cover property (q.fsm == st_rack ##[1:200] q.fsm == st_rdata);
  COV_WRITE: cover property (host_wr);
  COV_IRQ: cover property ($rose(irq));
  COV_FOREIGN: cover property (q.fsm == st_dev ##1 q.fsm == st_idle);
  COV_WRAP: cover property (ptr_inc && q.ptr == 8'hFF);

endmodule // tmsp_mgmt_port

// *** tb/tmsp_host_model.sv ***
// Host side of the 2-wire management bus: clock master and open-drain data driver.
// Assumes the bench resolves the data wire with a pull-up and feeds it back on sda.
`timescale 1ns/1ns

module tmsp_host_model (
  output logic      scl,
  output logic      sda_oe,
  input  wire logic sda
);
  // Released bus, clock standing high between frames
  initial begin
    scl    = 1'h1;
    sda_oe = 1'h0;
  end

  // One 800 ns bit; data moves 100 ns after the fall so it never races the clock
  task automatic bit_x(input logic b, output logic r);
    #100 sda_oe = ~b;
    #300 scl = 1'h1;
    #200 r = sda;
    #200 scl = 1'h0;
  endtask

  // Data falls while the clock is high; also serves as repeated start
  task automatic start();
    #100 sda_oe = 1'h0;
    #300 scl = 1'h1;
    #200 sda_oe = 1'h1;
    #200 scl = 1'h0;
  endtask

  // Data rises while the clock is high, then the bus rests
  task automatic stop();
    #100 sda_oe = 1'h1;
    #300 scl = 1'h1;
    #200 sda_oe = 1'h0;
    #400;
  endtask

  // Eight bits MSB first, ninth bit driven with a and sampled into k
  task automatic xfer(input logic [7:0] w, input logic a, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) bit_x(w[i], r[i]);
    bit_x(a, k);
  endtask
endmodule // tmsp_host_model

// *** tb/tb_tmsp_mgmt_port.sv ***
// Self-checking bench for the transceiver management port.
// Assumes tmsp_host_model masters the 2-wire bus and the data wire has a pull-up.
`timescale 1ns/1ns
`include "tmsp_regs.svh"

module tb_tmsp_mgmt_port;
  import tmsp_pkg::*;
  logic        ref_clk, reset, scl, host_oe, dut_o, dut_oe, strap_o, strap_oe, irq;
  logic        txd_pin, tx_on, flt_det, tx_fault, sig_det, rx_lost, reg_wr, reg_rd;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  tmsp_mon_t   mon;
  wire logic   sda;
  int          err_total, total_checks, cyc;

  // Open-drain wire: low if either party pulls, pull-up otherwise
  assign sda = ~(host_oe | (dut_oe & ~dut_o));

  tmsp_mgmt_port #(
    .HI_ALARM  ({16'h2000, {4{16'hFFFF}}}),
    .CAL_OFFSET({16'h0010, 64'h0})
  ) dut_u (
    .ref_clk(ref_clk), .reset(reset), .mgmt_clock_pin(scl), .mgmt_data_i(sda),
    .mgmt_data_o(dut_o), .mgmt_data_oe(dut_oe), .presence_strap_o(strap_o),
    .presence_strap_oe(strap_oe), .tx_disable_pin(txd_pin), .tx_enable(tx_on),
    .laser_fault_det(flt_det), .tx_fault(tx_fault), .rx_signal_detect(sig_det),
    .rx_signal_lost(rx_lost), .mon_raw(mon), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq)
  );

  tmsp_host_model host_u (.scl(scl), .sda_oe(host_oe), .sda(sda));

  // 10 MHz clock
  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic test_done();
    $display("Checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask

  task automatic rwr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rrd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1 rd_val = reg_rdata;
  endtask

  task automatic open_dev(input logic [6:0] dev, input logic rd, input logic exp_k);
    logic [7:0] r;
    logic       k;
    host_u.start();
    host_u.xfer({dev, rd}, 1'h1, r, k);
    chk(k, exp_k);
  endtask

  task automatic wb(input logic [7:0] d);
    logic [7:0] r;
    logic       k;
    host_u.xfer(d, 1'h1, r, k);
    chk(k, 1'h0);
  endtask

  // Host acks every byte but the last
  task automatic rb(input logic last, input logic [7:0] exp);
    logic [7:0] r;
    logic       k;
    host_u.xfer(8'hFF, last, r, k);
    chk(r, exp);
  endtask

  task automatic read_at(input logic [6:0] dev, input logic [7:0] p, input int n,
                         input logic [23:0] exp);
    open_dev(dev, 1'h0, 1'h0);
    wb(p);
    open_dev(dev, 1'h1, 1'h0);
    for (int i = n - 1; i >= 0; i--) rb(i == 0, exp[8*i+:8]);
    host_u.stop();
  endtask

  task automatic t_reset();
    chk({strap_oe, strap_o}, 2'h2);
    chk(tx_on, 1'h0);
    chk({rx_lost, irq}, 2'h0);
  endtask

  // Host writes are dropped there; a run crosses the top of the map
  task automatic t_id();
    rwr(`TMSP_REG_ID_PROG, 32'h0000FE11);
    rwr(`TMSP_REG_ID_PROG, 32'h0000FF22);
    rwr(`TMSP_REG_ID_PROG, 32'h00000033);
    open_dev(`TMSP_ADDR_ID, 1'h0, 1'h0);
    wb(8'hFF);
    wb(8'h55);
    host_u.stop();
    read_at(`TMSP_ADDR_ID, 8'hFE, 3, 24'h112233);
    rrd(`TMSP_REG_STATUS);
    chk(rd_val[13:6], 8'h01);
  endtask

  task automatic t_diag();
    open_dev(7'h52, 1'h0, 1'h1);
    host_u.stop();
    open_dev(`TMSP_ADDR_DIAG, 1'h0, 1'h0);
    wb(8'h80);
    wb(8'hA5);
    wb(8'h5A);
    host_u.stop();
    read_at(`TMSP_ADDR_DIAG, 8'h80, 2, 24'h00A55A);
    rrd(`TMSP_REG_IRQ_STAT);
    chk(rd_val, 32'h10);
    rwr(`TMSP_REG_IRQ_MASK, 32'h10);
    @(posedge ref_clk);
    chk(irq, 1'h1);
    rwr(`TMSP_REG_IRQ_STAT, 32'h10);
    @(posedge ref_clk);
    chk(irq, 1'h0);
    // Calibration type byte is read-only
    open_dev(`TMSP_ADDR_DIAG, 1'h0, 1'h0);
    wb(`TMSP_DIAG_CALTYPE);
    wb(8'hFF);
    host_u.stop();
    read_at(`TMSP_ADDR_DIAG, `TMSP_DIAG_CALTYPE, 1, 24'(`TMSP_CAL_INT));
    read_at(`TMSP_ADDR_DIAG, `TMSP_DIAG_MON_BASE, 2, 24'h0133);
    rwr(`TMSP_REG_CTRL, 32'h2);
    read_at(`TMSP_ADDR_DIAG, `TMSP_DIAG_CALTYPE, 1, 24'(`TMSP_CAL_EXT));
    read_at(`TMSP_ADDR_DIAG, `TMSP_DIAG_MON_BASE, 2, 24'h0123);
  endtask

  task automatic t_alarm();
    @(posedge ref_clk) mon.temp <= 16'h3000;
    repeat (8) @(posedge ref_clk);
    rrd(`TMSP_REG_STATUS);
    chk(rd_val[3], 1'h1);
    rrd(`TMSP_REG_IRQ_STAT);
    chk(rd_val[0], 1'h1);
  endtask

  task automatic t_los();
    @(posedge ref_clk) sig_det <= 1'h0;
    repeat (6) @(posedge ref_clk);
    chk(rx_lost, 1'h1);
    rrd(`TMSP_REG_IRQ_STAT);
    chk(rd_val[2], 1'h1);
    rwr(`TMSP_REG_IRQ_MASK, 32'h4);
    @(posedge ref_clk);
    chk(irq, 1'h1);
    rwr(`TMSP_REG_IRQ_STAT, 32'h4);
    @(posedge ref_clk);
    chk(irq, 1'h0);
    @(posedge ref_clk) sig_det <= 1'h1;
    repeat (6) @(posedge ref_clk);
    chk(rx_lost, 1'h0);
    rrd(8'h20);
    chk(rd_val, 32'h0);
  endtask

  task automatic t_tx();
    @(posedge ref_clk) txd_pin <= 1'h0;
    repeat (10) @(posedge ref_clk);
    chk(tx_on, 1'h1);
    @(posedge ref_clk) txd_pin <= 1'h1;
    repeat (`TMSP_TXDIS_CYCLES) @(posedge ref_clk);
    chk(tx_on, 1'h0);
    @(posedge ref_clk) flt_det <= 1'h1;
    repeat (6) @(posedge ref_clk);
    chk(tx_fault, 1'h1);
    @(posedge ref_clk) flt_det <= 1'h0;
    repeat (6) @(posedge ref_clk);
    chk(tx_fault, 1'h0);
  endtask

  // Main sequence; shutoff starts open, which the pull-up reads high
  initial begin
    reset     = 1'h1;
    txd_pin   = 1'h1;
    flt_det   = 1'h0;
    sig_det   = 1'h1;
    reg_wr    = 1'h0;
    reg_rd    = 1'h0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    mon       = '0;
    mon.temp  = 16'h0123;
    repeat (16) @(posedge ref_clk);
    reset <= 1'h0;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_id();
    t_diag();
    t_alarm();
    t_los();
    t_tx();
    test_done();
  end
endmodule // tb_tmsp_mgmt_port
